/* File: src/packer_pkg.sv */
// Constants and types for the sample packer with marker capture.
// Assumes one clock domain; registers are reached over APB.
package packer_pkg;
  localparam int          WORDS    = 4096;
  localparam int          AW       = 12;
  localparam logic [12:0] LVL_FULL = 13'h1000;
  localparam logic [7:0]  A_CTRL   = 8'h00;
  localparam logic [7:0]  A_POST   = 8'h04;
  localparam logic [7:0]  A_DAC    = 8'h08;
  localparam logic [7:0]  A_STAT   = 8'h0C;
  localparam logic [7:0]  A_DATA   = 8'h10;
  localparam logic [7:0]  A_WPTR   = 8'h14;
  localparam int          MARK_BIT = 15;
  localparam logic [23:0] CNT_LAST = 24'h000001;

  typedef struct packed {
    logic [3:0] sel;
    logic [3:0] top;
    logic       diff;
    logic       res16;
    logic       cont;
    logic       cnt_en;
    logic       ring;
    logic       trig_ana;
    logic       autoinc;
    logic       mark_en;
    logic       run;
  } ctrl_t;

  typedef enum logic [1:0] {IDLE, ARM, POST, DONE} acq_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } sample_t;

  typedef struct packed {
    logic [7:0]  zero;
    logic [3:0]  chan;
    acq_t        acq;
    logic        done;
    logic        ovf;
    logic [2:0]  rsv;
    logic [12:0] level;
  } stat_t;

  typedef struct packed {
    ctrl_t                  ctrl;
    logic [23:0]            post;
    logic [15:0]            dac;
    acq_t                   acq;
    logic [23:0]            cnt;
    logic [3:0]             chan;
    logic                   have_low;
    logic [15:0]            low;
    logic                   pend;
    logic [2:0]             mk;
    logic [2:0]             tgd;
    logic [2:0]             tga;
    logic                   ovf;
    logic                   done;
    logic [AW-1:0]          wp;
    logic [AW-1:0]          rp;
    logic [12:0]            level;
    logic [31:0]            prdata;
    logic [WORDS-1:0][31:0] mem;
  } st_t;
endpackage

/* File: src/sample_packer.sv */
// Packs converter samples in pairs into a longword store read over APB.
// Assumes sample words arrive on pclk; marker and trigger pins are async.
`timescale 1ns/1ps
module sample_packer (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                ce,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire packer_pkg::sample_t sample,
  input  wire logic                marker_in,
  input  wire logic                ext_trig,
  input  wire logic                cmp_trip,
  output logic      [3:0]          adc_channel,
  output logic      [15:0]         dac_level,
  output logic                     acquiring
);
  packer_pkg::st_t   s;
  packer_pkg::st_t   next_s;
  packer_pkg::stat_t stat;
  packer_pkg::stat_t clr;
  logic [15:0]       word;
  logic [31:0]       pair;
  logic [3:0]        top;
  logic              mrise;
  logic              trig;
  logic              tagok;
  logic              full;
  logic              store;
  logic              acc;
  logic              push;
  logic              pop;
  logic              wr;
  logic              rd;
  logic              mapped;

  always_comb begin
    next_s = s;
    clr    = pwdata;
    // The third stage only delays the second, so edges never see the first flop.
    mrise  = s.mk[1] & ~s.mk[2];
    trig   = s.ctrl.trig_ana ? (s.tga[1] & ~s.tga[2]) : (s.tgd[1] & ~s.tgd[2]);
    tagok  = s.ctrl.mark_en & ~s.ctrl.res16;
    word   = sample.data;
    if (tagok && s.pend) begin
      word[packer_pkg::MARK_BIT] = 1'b1;
    end
    pair   = {word, s.low};
    full   = (s.level == packer_pkg::LVL_FULL);
    // Differential operation uses two inputs per channel, so the scan top is halved.
    top    = s.ctrl.diff ? (s.ctrl.top >> 1) : s.ctrl.top;
    store  = sample.valid &&
             (s.acq == packer_pkg::POST || (s.acq == packer_pkg::ARM && s.ctrl.ring));
    // Linear mode stops taking samples once the store is full and a low half is already held.
    acc    = store && !(full && !s.ctrl.ring && s.have_low);
    push   = acc && s.have_low;
    wr     = psel && penable && pwrite && ce;
    rd     = psel && penable && !pwrite && ce && paddr == packer_pkg::A_DATA;
    // A read that meets an overwrite of the oldest entry does not pop.
    pop    = rd && s.level != '0 && !(push && full);
    mapped = paddr == packer_pkg::A_CTRL || paddr == packer_pkg::A_POST ||
             paddr == packer_pkg::A_DAC  || paddr == packer_pkg::A_STAT ||
             paddr == packer_pkg::A_DATA || paddr == packer_pkg::A_WPTR;
    stat       = '0;
    stat.chan  = s.chan;
    stat.acq   = s.acq;
    stat.done  = s.done;
    stat.ovf   = s.ovf;
    stat.level = s.level;

    next_s.mk  = {s.mk[1:0], marker_in};
    next_s.tgd = {s.tgd[1:0], ext_trig};
    next_s.tga = {s.tga[1:0], cmp_trip};

    if (wr) begin
      unique case (paddr)
        packer_pkg::A_CTRL: next_s.ctrl = pwdata[$bits(packer_pkg::ctrl_t)-1:0];
        packer_pkg::A_POST: next_s.post = pwdata[23:0];
        packer_pkg::A_DAC:  next_s.dac  = pwdata[15:0];
        packer_pkg::A_STAT: begin
          // Write one to clear; a fresh event later in this process wins.
          if (clr.ovf) next_s.ovf = 1'b0;
          if (clr.done) next_s.done = 1'b0;
        end
        default: ;
      endcase
    end

    if (acc && s.pend) begin
      next_s.pend = 1'b0;
    end
    if (mrise && tagok) begin
      next_s.pend = 1'b1;
    end

    if (store && !acc) begin
      next_s.ovf = 1'b1;
    end

    if (acc) begin
      if (!s.ctrl.autoinc) begin
        next_s.chan = s.ctrl.sel;
      end else if (s.chan >= top) begin
        next_s.chan = '0;
      end else begin
        next_s.chan = s.chan + 4'h1;
      end
      if (!s.have_low) begin
        next_s.low      = word;
        next_s.have_low = 1'b1;
      end else begin
        next_s.mem[s.wp] = pair;
        next_s.wp        = s.wp + 1'b1;
        next_s.have_low  = 1'b0;
      end
    end

    if (push && full) begin
      next_s.rp = s.rp + 1'b1;
    end else begin
      if (pop) begin
        next_s.rp = s.rp + 1'b1;
      end
      unique case ({push, pop})
        2'b10:   next_s.level = s.level + 13'h0001;
        2'b01:   next_s.level = s.level - 13'h0001;
        default: ;
      endcase
    end

    unique case (s.acq)
      packer_pkg::IDLE: begin
        if (s.ctrl.run) begin
          next_s.acq = packer_pkg::ARM;
          next_s.cnt = s.post;
        end
      end
      packer_pkg::ARM: begin
        if (trig) begin
          next_s.acq = packer_pkg::POST;
          next_s.cnt = s.post;
        end
      end
      packer_pkg::POST: begin
        if (acc && s.ctrl.cnt_en) begin
          if (s.cnt == packer_pkg::CNT_LAST) begin
            next_s.done = 1'b1;
            next_s.cnt  = s.post;
            next_s.acq  = s.ctrl.cont ? packer_pkg::ARM : packer_pkg::DONE;
          end else begin
            next_s.cnt = s.cnt - 24'h000001;
          end
        end
      end
      packer_pkg::DONE: ;
    endcase
    if (!s.ctrl.run) begin
      next_s.acq = packer_pkg::IDLE;
    end

    // Read data is caught in the setup phase so it comes from a flip-flop.
    if (psel && !penable && ce) begin
      unique case (paddr)
        packer_pkg::A_CTRL: next_s.prdata = 32'(s.ctrl);
        packer_pkg::A_POST: next_s.prdata = 32'(s.post);
        packer_pkg::A_DAC:  next_s.prdata = 32'(s.dac);
        packer_pkg::A_STAT: next_s.prdata = stat;
        packer_pkg::A_DATA: next_s.prdata = (s.level != '0) ? s.mem[s.rp] : '0;
        packer_pkg::A_WPTR: next_s.prdata = 32'(s.wp);
        default:            next_s.prdata = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign prdata      = s.prdata;
  assign pready      = ce;
  assign pslverr     = psel && penable && !mapped;
  assign adc_channel = s.chan;
  assign dac_level   = s.dac;
  assign acquiring   = (s.acq == packer_pkg::POST);

  property p_untagged;
    @(posedge pclk) disable iff (!presetn || !ce)
      acc && !tagok |-> word == sample.data;
  endproperty
  a_untagged: assert property (p_untagged) else $error("Untagged sample altered.");

  property p_tag;
    @(posedge pclk) disable iff (!presetn || !ce)
      acc && tagok && s.pend |-> word == {1'b1, sample.data[14:0]};
  endproperty
  a_tag: assert property (p_tag) else $error("Marker tag wrong.");

  property p_tag_once;
    @(posedge pclk) disable iff (!presetn || !ce)
      acc && s.pend && !mrise |=> !s.pend;
  endproperty
  a_tag_once: assert property (p_tag_once) else $error("Tag applied twice.");

  property p_pair;
    @(posedge pclk) disable iff (!presetn || !ce)
      acc && s.have_low |=> s.mem[$past(s.wp)] == $past(pair) && !s.have_low;
  endproperty
  a_pair: assert property (p_pair) else $error("Packed word wrong.");

  property p_wrap;
    @(posedge pclk) disable iff (!presetn || !ce)
      acc && s.ctrl.autoinc && s.chan == top |=> s.chan == 4'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("Channel did not wrap.");

  property p_stop;
    @(posedge pclk) disable iff (!presetn || !ce)
      s.acq == packer_pkg::POST && acc && s.ctrl.cnt_en && !s.ctrl.cont && s.ctrl.run &&
      s.cnt == packer_pkg::CNT_LAST |=> s.acq == packer_pkg::DONE && s.cnt == s.post;
  endproperty
  a_stop: assert property (p_stop) else $error("Frame did not stop.");

  property p_ring;
    @(posedge pclk) disable iff (!presetn || !ce)
      push && full && s.ctrl.ring |=> s.level == packer_pkg::LVL_FULL && s.rp == $past(s.wp) + 1'b1;
  endproperty
  a_ring: assert property (p_ring) else $error("Ring overwrite wrong.");

  property p_full;
    @(posedge pclk) disable iff (!presetn || !ce)
      store && full && !s.ctrl.ring && s.have_low |=> s.ovf && s.wp == $past(s.wp);
  endproperty
  a_full: assert property (p_full) else $error("Store past full.");

  property p_pend_set;
    @(posedge pclk) disable iff (!presetn || !ce)
      mrise && tagok |=> s.pend;
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("Marker not latched.");

  property p_pend_off;
    @(posedge pclk) disable iff (!presetn || !ce)
      !tagok && !s.pend |=> !s.pend;
  endproperty
  a_pend_off: assert property (p_pend_off) else $error("Disabled marker latched.");

  property p_low_hold;
    @(posedge pclk) disable iff (!presetn || !ce)
      acc && !s.have_low |=> s.have_low && s.low == $past(word);
  endproperty
  a_low_hold: assert property (p_low_hold) else $error("Lone sample not held.");

  property p_tag_bit;
    @(posedge pclk) disable iff (!presetn || !ce)
      acc && tagok && s.pend && !s.have_low |=> s.low[packer_pkg::MARK_BIT];
  endproperty
  a_tag_bit: assert property (p_tag_bit) else $error("Tag not stored.");

  property p_ovf_set;
    @(posedge pclk) disable iff (!presetn || !ce)
      store && !acc |=> s.ovf;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("Overflow not flagged.");

  property p_level_up;
    @(posedge pclk) disable iff (!presetn || !ce)
      push && !pop && !full |=> s.level == $past(s.level) + 13'h0001;
  endproperty
  a_level_up: assert property (p_level_up) else $error("Level did not rise.");

  property p_level_down;
    @(posedge pclk) disable iff (!presetn || !ce)
      pop && !push |=> s.level == $past(s.level) - 13'h0001;
  endproperty
  a_level_down: assert property (p_level_down) else $error("Level did not fall.");

  property p_empty_read;
    @(posedge pclk) disable iff (!presetn || !ce)
      rd && s.level == '0 && !push |=> s.level == '0 && s.rp == $past(s.rp);
  endproperty
  a_empty_read: assert property (p_empty_read) else $error("Empty store popped.");

  property p_trig_post;
    @(posedge pclk) disable iff (!presetn || !ce)
      s.acq == packer_pkg::ARM && trig && s.ctrl.run |=>
      s.acq == packer_pkg::POST && s.cnt == $past(s.post);
  endproperty
  a_trig_post: assert property (p_trig_post) else $error("Trigger not taken.");

  property p_run_off;
    @(posedge pclk) disable iff (!presetn || !ce)
      !s.ctrl.run |=> s.acq == packer_pkg::IDLE;
  endproperty
  a_run_off: assert property (p_run_off) else $error("Stopped run still active.");

  property p_count_down;
    @(posedge pclk) disable iff (!presetn || !ce)
      s.acq == packer_pkg::POST && acc && s.ctrl.cnt_en && s.ctrl.run &&
      s.cnt != packer_pkg::CNT_LAST |=> s.cnt == $past(s.cnt) - 24'h000001;
  endproperty
  a_count_down: assert property (p_count_down) else $error("Counter did not step.");

  property p_cont;
    @(posedge pclk) disable iff (!presetn || !ce)
      s.acq == packer_pkg::POST && acc && s.ctrl.cnt_en && s.ctrl.cont && s.ctrl.run &&
      s.cnt == packer_pkg::CNT_LAST |=> s.acq == packer_pkg::ARM && s.done;
  endproperty
  a_cont: assert property (p_cont) else $error("Frame did not rearm.");

  property p_forever;
    @(posedge pclk) disable iff (!presetn || !ce)
      s.acq == packer_pkg::POST && !s.ctrl.cnt_en && s.ctrl.run |=> s.acq == packer_pkg::POST;
  endproperty
  a_forever: assert property (p_forever) else $error("Free run stopped.");

  property p_no_store;
    @(posedge pclk) disable iff (!presetn || !ce)
      !store |=> s.wp == $past(s.wp) && s.have_low == $past(s.have_low);
  endproperty
  a_no_store: assert property (p_no_store) else $error("Stored while stopped.");

  property p_single_chan;
    @(posedge pclk) disable iff (!presetn || !ce)
      acc && !s.ctrl.autoinc |=> s.chan == $past(s.ctrl.sel);
  endproperty
  a_single_chan: assert property (p_single_chan) else $error("Single channel wrong.");

  property p_chan_step;
    @(posedge pclk) disable iff (!presetn || !ce)
      acc && s.ctrl.autoinc && s.chan < top |=> s.chan == $past(s.chan) + 4'h1;
  endproperty
  a_chan_step: assert property (p_chan_step) else $error("Channel did not step.");

  property p_chan_hold;
    @(posedge pclk) disable iff (!presetn || !ce)
      !acc |=> s.chan == $past(s.chan);
  endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("Channel moved idle.");

  property p_dac;
    @(posedge pclk) disable iff (!presetn || !ce)
      wr && paddr == packer_pkg::A_DAC |=> s.dac == $past(pwdata[15:0]);
  endproperty
  a_dac: assert property (p_dac) else $error("Threshold not loaded.");
endmodule // sample_packer

/* File: tb/adc_source.sv */
// Converter stand-in that streams sign-extended 12-bit samples on pclk.
// Assumes the bench holds go high for one cycle per wanted sample.
`timescale 1ns/1ps
module adc_source (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           go,
  input  wire logic [11:0]    base,
  output packer_pkg::sample_t sample
);
  logic [11:0] k;
  logic [11:0] v;
  assign v = base + k;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      k <= 12'h000;
      sample <= '0;
    end else begin
      k <= go ? k + 12'h001 : 12'h000;
      sample.valid <= go;
      // Between samples the word is inverted so a stale value is never reused.
      sample.data <= go ? {{4{v[11]}}, v} : ~sample.data;
    end
  end
endmodule // adc_source

/* File: tb/testbench.sv */
// Self-checking bench for the sample packer; APB master plus a converter model.
// Assumes a single 25 MHz clock and a store drained before each capture.
`timescale 1ns/1ps
module testbench;
  logic                pclk = 1'b0;
  logic                presetn = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [7:0]          paddr = 8'h00;
  logic [31:0]         pwdata = 32'h0;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic                err;
  logic [31:0]         rd;
  packer_pkg::sample_t sample;
  logic                marker_in = 1'b0;
  logic                ext_trig = 1'b0;
  logic                cmp_trip = 1'b0;
  logic [3:0]          adc_channel;
  logic [15:0]         dac_level;
  logic                acquiring;
  logic                go = 1'b0;
  logic [11:0]         base = 12'h000;
  int                  error_cnt = 0;
  int                  cmp_count = 0;

  always #20 pclk = ~pclk;

  sample_packer uut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample(sample),
    .marker_in(marker_in), .ext_trig(ext_trig), .cmp_trip(cmp_trip),
    .adc_channel(adc_channel), .dac_level(dac_level), .acquiring(acquiring));
  adc_source src (.pclk(pclk), .presetn(presetn), .go(go), .base(base), .sample(sample));

  function automatic logic [15:0] sx(input logic [11:0] v);
    return {{4{v[11]}}, v};
  endfunction

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Restarts from idle, pulses the marker, fires the selected trigger, streams n samples.
  task automatic capture(input logic [31:0] ctrl, input logic [23:0] post,
                         input logic [11:0] b, input int n);
    apb(1'b1, packer_pkg::A_CTRL, 32'h0);
    apb(1'b1, packer_pkg::A_POST, {8'h00, post});
    apb(1'b1, packer_pkg::A_CTRL, ctrl);
    marker_in <= 1'b1;
    repeat (4) @(posedge pclk);
    marker_in <= 1'b0;
    {cmp_trip, ext_trig} <= ctrl[3] ? 2'b10 : 2'b01;
    repeat (6) @(posedge pclk);
    chk("acquiring", 32'h1, {31'h0, acquiring});
    {cmp_trip, ext_trig} <= 2'b00;
    base <= b;
    go <= 1'b1;
    repeat (n) @(posedge pclk);
    go <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  // Scan of four channels; eight samples offered, six kept, packed low-first.
  task automatic scan_pack;
    capture(32'h0000_0625, 24'h000006, 12'hFFE, 8);
    apb(1'b0, packer_pkg::A_STAT, 32'h0);
    chk("stat", {3'b111, 13'h0003}, {rd[19:17], rd[12:0]});
    chk("channel", 32'h2, {28'h0, adc_channel});
    chk("stopped", 32'h0, {31'h0, acquiring});
    for (int j = 0; j < 3; j++) begin
      apb(1'b0, packer_pkg::A_DATA, 32'h0);
      chk("word", {sx(12'hFFF + 2 * j), sx(12'hFFE + 2 * j)}, rd);
    end
  endtask

  // Marker enabled, disabled and with a 16-bit converter; digital and analog trigger.
  task automatic marker_modes;
    logic [31:0] cfg [3] = '{32'h0000_0023, 32'h0000_0029, 32'h0000_00A3};
    for (int i = 0; i < 3; i++) begin
      capture(cfg[i], 24'h000002, 12'h010, 2);
      apb(1'b0, packer_pkg::A_DATA, 32'h0);
      chk("marked", {16'h0011, (i == 0) ? 16'h8010 : 16'h0010}, rd);
    end
    apb(1'b0, packer_pkg::A_DATA, 32'h0);
    chk("empty", 32'h0, rd);
  endtask

  task automatic regs;
    apb(1'b1, packer_pkg::A_DAC, 32'h0000_A5C3);
    @(negedge pclk);
    chk("dac", 32'h0000_A5C3, {16'h0, dac_level});
    apb(1'b0, 8'h18, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    chk("unmapped", 32'h0, rd);
  endtask

  task automatic complete_run;
    if (error_cnt == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    complete_run();
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    scan_pack();
    marker_modes();
    regs();
    complete_run();
  end
endmodule // testbench
